// *** core/dpi_pkg.sv ***
// package for the ddr memory pin interface: widths, commands, timing
package dpi_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int DATA_W = 16;
  localparam int CS_W = 1;
  // link clock figure used only to size the write hold cycle count
  localparam int CLK_PERIOD_NS = 50;
  localparam int WR_HOLD_NS = 100;
  localparam int WR_HOLD_CYC = (WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // command codes: {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } dpi_cmd_type;
  typedef struct packed {
    dpi_cmd_type cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [CS_W-1:0] cs;
  } dpi_req_type;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] mask;
  } dpi_wdata_type;
  localparam logic [CS_W-1:0] CS_IDLE = '1;
  localparam logic [ADDR_W-1:0] ADDR_RST = '0;
  localparam logic [BANK_W-1:0] BANK_RST = '0;
endpackage

// *** core/dpi_pin_if.sv ***
// ddr memory pin interface: command, clock, data and strobe pins
`timescale 1ns/1ps
module dpi_pin_if (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic mclk_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire dpi_pkg::dpi_req_type req_in,
  input wire dpi_pkg::dpi_wdata_type wdata_in,
  input wire logic wr_phase_in,
  input wire logic rd_phase_in,
  input wire logic cke_in,
  input wire logic odt_in,
  input wire logic diff_strobe_in,
  output logic [dpi_pkg::ADDR_W-1:0] mem_address_bus_out,
  output logic [dpi_pkg::BANK_W-1:0] mem_bank_select_out,
  output logic row_strobe_out,
  output logic column_strobe_out,
  output logic mem_write_enable_out,
  output logic [dpi_pkg::CS_W-1:0] mem_chip_select_out,
  output logic mem_clock_out,
  output logic mem_clock_n_out,
  output logic mem_clock_enable_out,
  output logic termination_control_out,
  input wire logic [dpi_pkg::DATA_W-1:0] mem_data_bus_in,
  output logic [dpi_pkg::DATA_W-1:0] mem_data_bus_out,
  output logic mem_data_bus_oe_n_out,
  output logic lower_byte_mask_out,
  output logic upper_byte_mask_out,
  input wire logic lower_byte_strobe_in,
  input wire logic lower_byte_strobe_n_in,
  output logic lower_byte_strobe_out,
  output logic lower_byte_strobe_n_out,
  output logic lower_byte_strobe_oe_n_out,
  output logic lower_byte_strobe_n_oe_n_out,
  input wire logic upper_byte_strobe_in,
  input wire logic upper_byte_strobe_n_in,
  output logic upper_byte_strobe_out,
  output logic upper_byte_strobe_n_out,
  output logic upper_byte_strobe_oe_n_out,
  output logic upper_byte_strobe_n_oe_n_out,
  output logic [dpi_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out
);
  import dpi_pkg::*;

  logic [2:0] mclk_sync_q;
  logic mclk_lvl_q;
  logic mclk_rise;
  logic mclk_fall;
  logic [2:0] lstb_sync_q;
  logic [2:0] ustb_sync_q;
  logic lstb_lvl_q;
  logic ustb_lvl_q;
  logic stb_edge;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [DATA_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BANK_W-1:0] bank_q;
  logic [2:0] cmd_q;
  logic [CS_W-1:0] cs_q;
  logic wr_drive_q;
  logic wstb_q;
  dpi_wdata_type wdata_q;

  function automatic logic is_edge(input logic a, input logic b, input logic lvl);
    is_edge = (a == b) && (b != lvl);
  endfunction

  // link clock: three flops, change counts when 2nd and 3rd agree
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mclk_sync_q <= 3'h0;
      mclk_lvl_q <= 1'b0;
    end else begin
      mclk_sync_q <= {mclk_sync_q[1:0], mclk_in};
      if (mclk_sync_q[1] == mclk_sync_q[2]) begin
        mclk_lvl_q <= mclk_sync_q[2];
      end
    end
  end
  assign mclk_rise = is_edge(mclk_sync_q[1], mclk_sync_q[2], mclk_lvl_q) && mclk_sync_q[2];
  assign mclk_fall = is_edge(mclk_sync_q[1], mclk_sync_q[2], mclk_lvl_q) && !mclk_sync_q[2];

  assign mem_clock_out = mclk_lvl_q;
  assign mem_clock_n_out = ~mclk_lvl_q;
  assign mem_clock_enable_out = cke_in;
  assign termination_control_out = odt_in;

  // one command per memory clock, launched on falling edge so stable at rise
  assign req_ready_out = mclk_fall;

  // chip select and truth table encoding
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= ADDR_RST;
      bank_q <= BANK_RST;
      cmd_q <= CMD_NOP;
      cs_q <= CS_IDLE;
    end else if (mclk_fall) begin
      if (req_valid_in) begin
        addr_q <= req_in.addr;
        bank_q <= req_in.bank;
        cmd_q <= req_in.cmd;
        cs_q <= req_in.cs;
      end else begin
        cmd_q <= CMD_NOP;
        cs_q <= CS_IDLE;
      end
    end
  end
  assign mem_address_bus_out = addr_q;
  assign mem_bank_select_out = bank_q;
  assign row_strobe_out = cmd_q[2];
  assign column_strobe_out = cmd_q[1];
  assign mem_write_enable_out = cmd_q[0];
  assign mem_chip_select_out = cs_q;

  // write strobe toggles with each memory clock edge during write phase
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_drive_q <= 1'b0;
      wstb_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      if (mclk_rise || mclk_fall) begin
        wr_drive_q <= wr_phase_in;
        wstb_q <= wr_phase_in ? mclk_rise : 1'b0;
        // masks launched with each data beat
        wdata_q <= wdata_in;
      end
    end
  end
  assign mem_data_bus_out = wdata_q.data;
  assign mem_data_bus_oe_n_out = ~wr_drive_q;
  assign lower_byte_mask_out = wdata_q.mask[0];
  assign upper_byte_mask_out = wdata_q.mask[1];
  assign lower_byte_strobe_out = wstb_q;
  assign upper_byte_strobe_out = wstb_q;
  // complement driven only in differential mode
  assign lower_byte_strobe_n_out = diff_strobe_in ? ~wstb_q : 1'b0;
  assign upper_byte_strobe_n_out = diff_strobe_in ? ~wstb_q : 1'b0;
  assign lower_byte_strobe_oe_n_out = ~wr_drive_q;
  assign upper_byte_strobe_oe_n_out = ~wr_drive_q;
  assign lower_byte_strobe_n_oe_n_out = ~(wr_drive_q && diff_strobe_in);
  assign upper_byte_strobe_n_oe_n_out = ~(wr_drive_q && diff_strobe_in);

  // read capture on received strobe edges
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lstb_sync_q <= 3'h0;
      ustb_sync_q <= 3'h0;
      lstb_lvl_q <= 1'b0;
      ustb_lvl_q <= 1'b0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      lstb_sync_q <= {lstb_sync_q[1:0], lower_byte_strobe_in};
      ustb_sync_q <= {ustb_sync_q[1:0], upper_byte_strobe_in};
      if (lstb_sync_q[1] == lstb_sync_q[2]) begin
        lstb_lvl_q <= lstb_sync_q[2];
      end
      if (ustb_sync_q[1] == ustb_sync_q[2]) begin
        ustb_lvl_q <= ustb_sync_q[2];
      end
      dq_s1_q <= mem_data_bus_in;
      dq_s2_q <= dq_s1_q;
    end
  end
  assign stb_edge = is_edge(lstb_sync_q[1], lstb_sync_q[2], lstb_lvl_q)
                 || is_edge(ustb_sync_q[1], ustb_sync_q[2], ustb_lvl_q);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_phase_in && !wr_drive_q && stb_edge;
      if (rd_phase_in && !wr_drive_q && stb_edge) begin
        rd_data_q <= dq_s2_q;
      end
    end
  end
  assign rd_data_out = rd_data_q;
  assign rd_valid_out = rd_valid_q;

  // complement strobe inputs are not needed when sampling by level
  logic unused_n;
  assign unused_n = lower_byte_strobe_n_in ^ upper_byte_strobe_n_in;

  a_clk_compl: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mem_clock_n_out == !mem_clock_out) else $error("clock complement wrong");
  a_cke_follow: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mem_clock_enable_out == cke_in) else $error("cke not active high");
  a_odt_follow: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    termination_control_out == odt_in) else $error("odt wrong");
  a_cs_idle: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mclk_fall && !req_valid_in |=> mem_chip_select_out == CS_IDLE && cmd_q == CMD_NOP)
    else $error("idle cycle not deselected");
  a_bank_take: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mclk_fall && req_valid_in |=> mem_bank_select_out == $past(req_in.bank))
    else $error("bank not launched");
  a_cas_take: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mclk_fall && req_valid_in |=> column_strobe_out == $past(req_in.cmd[1]))
    else $error("column strobe wrong");
  a_cmd_stable: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mclk_rise |-> $stable(cmd_q) && $stable(bank_q)) else $error("command moves at rise");
  a_single_n: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !diff_strobe_in |-> lower_byte_strobe_n_oe_n_out && upper_byte_strobe_n_oe_n_out)
    else $error("complement driven single-ended");
  a_mask_beat: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (mclk_rise || mclk_fall) |=> lower_byte_mask_out == $past(wdata_in.mask[0])
    && upper_byte_mask_out == $past(wdata_in.mask[1])) else $error("mask not launched");
  a_wr_strobe: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (mclk_rise || mclk_fall) && !wr_phase_in |=> lower_byte_strobe_oe_n_out
    && upper_byte_strobe_oe_n_out) else $error("strobe driven outside write");
endmodule // dpi_pin_if

// *** tb/dpi_mem_model.sv ***
// memory-side model: decodes only the read command, stores write bytes, answers reads
`timescale 1ns/1ps
module dpi_mem_model
  import dpi_pkg::*;
(
  input wire logic ck_in,
  input wire logic cs_in,
  input wire logic [2:0] cmd_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [1:0] dm_in,
  input wire logic dqs_in,
  input wire logic wr_in,
  input wire logic [DATA_W-1:0] rd_val_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dqs_out,
  output logic [DATA_W-1:0] mem_q_out
);
  initial begin
    dq_out = '0;
    dqs_out = 1'b0;
    mem_q_out = '0;
  end
  always @(dqs_in) begin
    // settle after the strobe edge so enable and data are not raced
    #1;
    if (wr_in && !dm_in[0])
      mem_q_out[7:0] = dq_in[7:0];
    if (wr_in && !dm_in[1])
      mem_q_out[15:8] = dq_in[15:8];
  end
  always @(posedge ck_in) begin
    if (cs_in == 1'b0 && cmd_in == CMD_RD) begin
      dq_out = rd_val_in;
      repeat (4) begin
        @(ck_in);
        dqs_out = ~dqs_out;
      end
      // released bus shows the inverse, not a stale copy
      dq_out = ~rd_val_in;
    end
  end
endmodule // dpi_mem_model

// *** tb/ddr_memory_pin_interface_bench.sv ***
// bench: command pins, clock pins, writes and reads against the memory model
`timescale 1ns/1ps
module ddr_memory_pin_interface_bench;
  import dpi_pkg::*;
  logic ref_clk_in = 1'b0, resetn_in = 1'b0, mclk_in = 1'b0, req_valid_in = 1'b0;
  logic wr_phase_in = 1'b0, rd_phase_in = 1'b0, cke_in = 1'b0, odt_in = 1'b0;
  logic diff_strobe_in = 1'b0;
  dpi_req_type req_in = '{CMD_NOP, BANK_RST, ADDR_RST, CS_IDLE};
  dpi_wdata_type wdata_in = '0;
  logic rdy, ras, cas, we, mck, mck_n, cke_o, odt_o, oe_n, ldm, udm, rdv;
  logic ls, ls_oe, ls_noe, us, us_oe, us_noe, ls_w, us_w, m_dqs, ls_n, us_n;
  logic [DATA_W-1:0] dq_o, dq_w, m_dq, m_q, rdd, exp_q, rd_val = '0;
  logic [ADDR_W-1:0] addr;
  logic [BANK_W-1:0] bank;
  logic [CS_W-1:0] cs;
  int n_errors = 0, check_count = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  initial begin
    #13;
    forever #200 mclk_in = ~mclk_in;
  end
  assign dq_w = (oe_n == 1'b0) ? dq_o : m_dq;
  assign ls_w = (ls_oe == 1'b0) ? ls : m_dqs;
  assign us_w = (us_oe == 1'b0) ? us : m_dqs;
  dpi_pin_if i_dpi_pin_if (
    .ref_clk_in, .resetn_in, .mclk_in, .req_valid_in, .req_ready_out(rdy), .req_in,
    .wdata_in, .wr_phase_in, .rd_phase_in, .cke_in, .odt_in, .diff_strobe_in,
    .mem_address_bus_out(addr), .mem_bank_select_out(bank), .row_strobe_out(ras),
    .column_strobe_out(cas), .mem_write_enable_out(we), .mem_chip_select_out(cs),
    .mem_clock_out(mck), .mem_clock_n_out(mck_n), .mem_clock_enable_out(cke_o),
    .termination_control_out(odt_o), .mem_data_bus_in(dq_w), .mem_data_bus_out(dq_o),
    .mem_data_bus_oe_n_out(oe_n), .lower_byte_mask_out(ldm), .upper_byte_mask_out(udm),
    .lower_byte_strobe_in(ls_w), .lower_byte_strobe_n_in(~ls_w),
    .lower_byte_strobe_out(ls), .lower_byte_strobe_n_out(ls_n),
    .lower_byte_strobe_oe_n_out(ls_oe), .lower_byte_strobe_n_oe_n_out(ls_noe),
    .upper_byte_strobe_in(us_w), .upper_byte_strobe_n_in(~us_w),
    .upper_byte_strobe_out(us), .upper_byte_strobe_n_out(us_n),
    .upper_byte_strobe_oe_n_out(us_oe), .upper_byte_strobe_n_oe_n_out(us_noe),
    .rd_data_out(rdd), .rd_valid_out(rdv));
  dpi_mem_model i_dpi_mem_model (.ck_in(mck), .cs_in(cs[0]), .cmd_in({ras, cas, we}),
    .dq_in(dq_w), .dm_in({udm, ldm}), .dqs_in(ls_w), .wr_in(~oe_n), .rd_val_in(rd_val),
    .dq_out(m_dq), .dqs_out(m_dqs), .mem_q_out(m_q));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // request held from a falling ref edge until a ready cycle is taken
  task automatic issue(input dpi_cmd_type c, input logic [2:0] b, input logic [13:0] a,
                       input logic s);
    int n;
    req_in = '{c, b, a, s};
    req_valid_in = 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("ready", 1, rdy);
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    @(negedge ref_clk_in);
  endtask
  task automatic t_cmds();
    for (int i = 0; i < 8; i++) begin
      issue(dpi_cmd_type'(i), i[2:0], {i[2:0], 11'h5a3}, 1'b0);
      chk("cmd", i, {ras, cas, we});
      chk("bank", i, bank);
      chk("addr", {i[2:0], 11'h5a3}, addr);
      chk("cs", 0, cs);
    end
    issue(CMD_ACT, 3'h5, 14'h1, 1'b1);
    chk("cs idle", 1, cs);
  endtask
  task automatic t_clk();
    int ne;
    logic pm;
    ne = 0;
    pm = mck;
    for (int i = 0; i < 40; i++) begin
      cke_in = i[1];
      odt_in = i[2];
      @(negedge ref_clk_in);
      if (mck !== pm)
        ne++;
      pm = mck;
      chk("ck_n", !mck, mck_n);
      chk("cke", i[1], cke_o);
      chk("odt", i[2], odt_o);
    end
    // 2000 ns window of a 400 ns clock holds ten edges
    chk("ck edges", 10, ne);
  endtask
  task automatic t_write();
    int n;
    logic [15:0] d;
    for (int m = 0; m < 4; m++) begin
      d = 16'h00a5 * (m + 1) + 16'h1200;
      diff_strobe_in = m[0];
      wdata_in = '{d, m[1:0]};
      if (!m[0])
        exp_q[7:0] = d[7:0];
      if (!m[1])
        exp_q[15:8] = d[15:8];
      wr_phase_in = 1'b1;
      issue(CMD_WR, 3'h1, 14'h10, 1'b0);
      n = 0;
      while (oe_n !== 1'b0 && n < 40) begin
        @(negedge ref_clk_in);
        n++;
      end
      chk("wdata", d, dq_o);
      chk("mask", m, {udm, ldm});
      chk("ls_n oe", m[0] ? ls_oe : 1'b1, ls_noe);
      chk("us_n oe", m[0] ? us_oe : 1'b1, us_noe);
      chk("ls_n", m[0] & !ls, ls_n);
      chk("us_n", m[0] & !us, us_n);
      chk("us", ls, us);
      repeat (8) @(negedge ref_clk_in);
      wr_phase_in = 1'b0;
      repeat (16) @(negedge ref_clk_in);
      chk("stored", exp_q, m_q);
    end
  endtask
  task automatic t_read();
    int n;
    rd_val = 16'hc35a;
    rd_phase_in = 1'b1;
    issue(CMD_RD, 3'h2, 14'h20, 1'b0);
    n = 0;
    while (rdv !== 1'b1 && n < 80) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("rd valid", 1, rdv);
    chk("rd data", 16'hc35a, rdd);
    rd_phase_in = 1'b0;
  endtask
  initial begin
    exp_q = '0;
    repeat (10) @(negedge ref_clk_in);
    chk("rst cs", CS_IDLE, cs);
    chk("rst oe", 1, oe_n);
    resetn_in = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    t_cmds();
    t_clk();
    t_write();
    t_read();
    stop_test();
  end
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule // ddr_memory_pin_interface_bench
